// [rtl/bit_test_change_clear.sv]
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "bit_test_change_clear_map.svh"

module bit_test_change_clear #(
    parameter int REG_COUNT = 8
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack
);

    // Merge a bus write into a word under its byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Flip or clear the bits under the mask
    function automatic logic [31:0] apply_op(input logic [31:0] val,
                                             input logic [31:0] mask,
                                             input logic        clear);
        return clear ? (val & ~mask) : (val ^ mask);
    endfunction : apply_op

    logic [31:0]              gp_data_register [REG_COUNT];
    logic [31:0]              pointer_register [REG_COUNT];
    logic [15:0]              opcode_reg;
    logic [15:0]              ext_reg;
    logic [31:0]              ea_ext_reg;
    logic [4:0]               ccr_reg;
    logic                     busy_reg;
    logic                     done_reg;
    logic                     illegal_reg;
    logic                     resp_reg;
    logic [31:0]              readdata_reg;
    logic                     clear_reg;
    logic [2:0]               bitn_reg;
    logic [31:0]              addr_reg;
    logic [7:0]               rbyte_reg;
    bit_test_pkg::exec_state_t state_reg;
    bit_test_pkg::exec_state_t state_next;

    logic        bus_take;
    logic        bus_wr;
    logic        start;
    logic [2:0]  mode;
    logic [2:0]  rn;
    logic        is_dyn;
    logic        is_static;
    logic        is_clear;
    logic        mode_ok;
    logic        legal;
    logic [7:0]  bit_src;
    logic [31:0] reg_mask;
    logic [31:0] reg_old;
    logic [31:0] reg_new;
    logic [31:0] ea_addr;
    logic [7:0]  byte_mask;
    logic        reg_exec;
    logic        mem_exec;

    // One wait state on every access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~resp_reg;
    assign bus_take        = (avs_read | avs_write) & resp_reg;
    assign bus_wr          = avs_write & resp_reg;
    assign start           = bus_wr && avs_address == `OFS_CONTROL
                             && avs_byteenable[0] && avs_writedata[`CTRL_START_BIT];
    assign avs_readdata    = readdata_reg;

    // Field split of the opcode
    assign mode = opcode_reg[5:3];
    assign rn   = opcode_reg[2:0];

    // Dynamic and static form recognition
    assign is_dyn    = opcode_reg[15:12] == `DYN_TOP_ZERO
                       && (opcode_reg[8:6] == `DYN_INVERT
                           || opcode_reg[8:6] == `DYN_CLEAR);
    assign is_static = (opcode_reg[15:6] == `STATIC_INVERT
                        || opcode_reg[15:6] == `STATIC_CLEAR)
                       && ext_reg[15:8] == `EXT_TOP_ZERO;
    assign is_clear  = is_dyn ? (opcode_reg[8:6] == `DYN_CLEAR)
                              : (opcode_reg[15:6] == `STATIC_CLEAR);

    // Only data alterable destinations pass
    always_comb begin
        case (mode)
            `MODE_DATA, `MODE_INDIRECT, `MODE_POSTINC,
            `MODE_PREDEC, `MODE_DISP, `MODE_INDEXED: mode_ok = 1'b1;
            `MODE_EXTRA: mode_ok = (rn == `ABS_SHORT) || (rn == `ABS_LONG);
            default:     mode_ok = 1'b0;
        endcase
    end
    assign legal = (is_dyn || is_static) && mode_ok;

    // Bit number source; only the low bits survive the modulo
    assign bit_src  = is_dyn ? gp_data_register[opcode_reg[11:9]][7:0]
                             : ext_reg[7:0];
    assign reg_mask = 32'h0000_0001 << bit_src[4:0];
    assign reg_old  = gp_data_register[rn];
    assign reg_new  = apply_op(reg_old, reg_mask, is_clear);
    assign reg_exec = state_reg == bit_test_pkg::ST_DECODE && legal
                      && mode == `MODE_DATA;
    assign mem_exec = state_reg == bit_test_pkg::ST_DECODE && legal
                      && mode != `MODE_DATA;

    // Effective byte address; index scaling is left to software in the extension
    always_comb begin
        case (mode)
            `MODE_PREDEC: ea_addr = pointer_register[rn] - `BYTE_STEP;
            `MODE_DISP, `MODE_INDEXED: ea_addr = pointer_register[rn] + ea_ext_reg;
            `MODE_EXTRA: ea_addr = (rn == `ABS_SHORT)
                                   ? {{16{ea_ext_reg[15]}}, ea_ext_reg[15:0]}
                                   : ea_ext_reg;
            default:     ea_addr = pointer_register[rn];
        endcase
    end

    // Bus response and read data capture
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resp_reg     <= 1'b0;
            readdata_reg <= 32'h0000_0000;
        end else begin
            resp_reg <= (avs_read | avs_write) & ~resp_reg;
            if (avs_read && !resp_reg) begin
                if (avs_address >= `OFS_DATA_BASE && avs_address < `OFS_POINTER_BASE) begin
                    readdata_reg <= gp_data_register[avs_address[4:2]];
                end else if (avs_address >= `OFS_POINTER_BASE
                             && avs_address < 8'h80) begin
                    readdata_reg <= pointer_register[avs_address[4:2]];
                end else begin
                    case (avs_address)
                        `OFS_STATUS: readdata_reg <= {23'h000000, ccr_reg, 1'b0,
                                                      illegal_reg, done_reg, busy_reg};
                        `OFS_OPCODE:       readdata_reg <= {16'h0000, opcode_reg};
                        `OFS_EXTENSION:    readdata_reg <= {16'h0000, ext_reg};
                        `OFS_EA_EXTENSION: readdata_reg <= ea_ext_reg;
                        `OFS_CCR:          readdata_reg <= {27'h0000000, ccr_reg};
                        default:           readdata_reg <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // Instruction words; ignored while an instruction runs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            opcode_reg <= `OPCODE_RESET;
            ext_reg    <= 16'h0000;
            ea_ext_reg <= 32'h0000_0000;
        end else if (bus_wr && !busy_reg) begin
            case (avs_address)
                `OFS_OPCODE: opcode_reg <= 16'(be_merge({16'h0000, opcode_reg},
                                                        avs_writedata, avs_byteenable));
                `OFS_EXTENSION: ext_reg <= 16'(be_merge({16'h0000, ext_reg},
                                                        avs_writedata, avs_byteenable));
                `OFS_EA_EXTENSION: ea_ext_reg <= be_merge(ea_ext_reg, avs_writedata,
                                                          avs_byteenable);
                default: ;
            endcase
        end
    end

    // Register file; execution writes win over a bus write in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                gp_data_register[i] <= 32'h0000_0000;
                pointer_register[i] <= 32'h0000_0000;
            end
        end else begin
            if (bus_wr && avs_address >= `OFS_DATA_BASE && avs_address < `OFS_POINTER_BASE) begin
                gp_data_register[avs_address[4:2]] <=
                    be_merge(gp_data_register[avs_address[4:2]], avs_writedata, avs_byteenable);
            end
            if (bus_wr && avs_address >= `OFS_POINTER_BASE && avs_address < 8'h80) begin
                pointer_register[avs_address[4:2]] <=
                    be_merge(pointer_register[avs_address[4:2]], avs_writedata, avs_byteenable);
            end
            if (reg_exec) begin
                gp_data_register[rn] <= reg_new;
            end
            if (mem_exec && mode == `MODE_POSTINC) begin
                pointer_register[rn] <= pointer_register[rn] + `BYTE_STEP;
            end
            if (mem_exec && mode == `MODE_PREDEC) begin
                pointer_register[rn] <= ea_addr;
            end
        end
    end

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bit_test_pkg::ST_IDLE:      if (start) state_next = bit_test_pkg::ST_DECODE;
            bit_test_pkg::ST_DECODE:    state_next = mem_exec ? bit_test_pkg::ST_MEM_READ
                                                              : bit_test_pkg::ST_FINISH;
            bit_test_pkg::ST_MEM_READ:  if (mem_ack) state_next = bit_test_pkg::ST_MEM_WRITE;
            bit_test_pkg::ST_MEM_WRITE: if (mem_ack) state_next = bit_test_pkg::ST_FINISH;
            bit_test_pkg::ST_FINISH:    state_next = bit_test_pkg::ST_IDLE;
            default:                    state_next = bit_test_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= bit_test_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Memory operand latches
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clear_reg <= 1'b0;
            bitn_reg  <= 3'h0;
            addr_reg  <= 32'h0000_0000;
            rbyte_reg <= 8'h00;
        end else begin
            if (mem_exec) begin
                clear_reg <= is_clear;
                bitn_reg  <= bit_src[2:0];
                addr_reg  <= ea_addr;
            end
            if (state_reg == bit_test_pkg::ST_MEM_READ && mem_ack) begin
                rbyte_reg <= mem_rdata;
            end
        end
    end

    // Byte access; same address for read and write back
    assign byte_mask = 8'h01 << bitn_reg;
    assign mem_req   = state_reg == bit_test_pkg::ST_MEM_READ
                       || state_reg == bit_test_pkg::ST_MEM_WRITE;
    assign mem_we    = state_reg == bit_test_pkg::ST_MEM_WRITE;
    assign mem_addr  = addr_reg;
    assign mem_wdata = 8'(apply_op({24'h000000, rbyte_reg},
                                   {24'h000000, byte_mask}, clear_reg));

    // Flags; an instruction moves only Z, from the bit as it was before the write; a bus write loads all five
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ccr_reg <= `CCR_RESET;
        end else if (reg_exec) begin
            ccr_reg[`CCR_Z_BIT] <= ~|(reg_old & reg_mask);
        end else if (state_reg == bit_test_pkg::ST_MEM_READ && mem_ack) begin
            ccr_reg[`CCR_Z_BIT] <= ~|(mem_rdata & byte_mask);
        end else if (bus_wr && !busy_reg && avs_address == `OFS_CCR && avs_byteenable[0]) begin
            ccr_reg <= avs_writedata[4:0];
        end
    end

    // Status; a new start clears done and illegal
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_reg    <= 1'b0;
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            if (start && !busy_reg) begin
                busy_reg    <= 1'b1;
                done_reg    <= 1'b0;
                illegal_reg <= 1'b0;
            end
            if (state_reg == bit_test_pkg::ST_DECODE && !legal) begin
                illegal_reg <= 1'b1;
            end
            if (state_reg == bit_test_pkg::ST_FINISH) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    invert_reg_a: assert property (reg_exec && !is_clear |=>
        gp_data_register[$past(rn)] == ($past(reg_old) ^ $past(reg_mask)))
        else $error("invert left wrong register value");

    clear_reg_a: assert property (reg_exec && is_clear |=>
        gp_data_register[$past(rn)] == ($past(reg_old) & ~$past(reg_mask)))
        else $error("clear left wrong register value");

    zero_flag_a: assert property (reg_exec |=>
        ccr_reg[`CCR_Z_BIT] == !$past(reg_old[bit_src[4:0]])
        && ccr_reg[1:0] == $past(ccr_reg[1:0]) && ccr_reg[4:3] == $past(ccr_reg[4:3]))
        else $error("zero flag or other flags wrong");

    mod32_sel_a: assert property (reg_exec |-> $onehot(reg_mask)
        && reg_mask[bit_src[4:0]])
        else $error("register bit select not modulo 32");

    byte_change_a: assert property (mem_we && !clear_reg |->
        $onehot(mem_wdata ^ rbyte_reg) && (mem_wdata ^ rbyte_reg) == (8'h01 << bitn_reg))
        else $error("memory byte invert touched wrong bits");

    same_addr_a: assert property (mem_req && !mem_we && mem_ack |=>
        mem_req && mem_we && $stable(mem_addr))
        else $error("write back not at read address");

    reject_mode_a: assert property (state_reg == bit_test_pkg::ST_DECODE
        && (mode == 3'h1 || (mode == `MODE_EXTRA && rn > `ABS_LONG)) |=>
        illegal_reg && !mem_req ##1 done_reg && !busy_reg)
        else $error("illegal destination not rejected");

    dyn_source_a: assert property (state_reg == bit_test_pkg::ST_DECODE && is_dyn |->
        reg_mask == (32'h0000_0001 << gp_data_register[opcode_reg[11:9]][4:0]))
        else $error("dynamic bit number from wrong register");

    mem_flag_a: assert property (mem_req && !mem_we && mem_ack |=>
        ccr_reg[`CCR_Z_BIT] == ~|($past(mem_rdata) & byte_mask))
        else $error("zero flag wrong on memory operand");

    bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");

endmodule : bit_test_change_clear

// [rtl/bit_test_change_clear_map.svh]
`ifndef BIT_TEST_CHANGE_CLEAR_MAP_SVH
`define BIT_TEST_CHANGE_CLEAR_MAP_SVH

// Register byte offsets, one aligned word each
`define OFS_CONTROL      8'h00
`define OFS_STATUS       8'h04
`define OFS_OPCODE       8'h08
`define OFS_EXTENSION    8'h0C
`define OFS_EA_EXTENSION 8'h10
`define OFS_CCR          8'h14
`define OFS_DATA_BASE    8'h40
`define OFS_POINTER_BASE 8'h60

// Control and status fields
`define CTRL_START_BIT   0
`define STAT_BUSY_BIT    0
`define STAT_DONE_BIT    1
`define STAT_ILLEGAL_BIT 2
`define STAT_CCR_LSB     4

// Condition flag positions inside the five-bit flag field
`define CCR_C_BIT 0
`define CCR_V_BIT 1
`define CCR_Z_BIT 2
`define CCR_N_BIT 3
`define CCR_X_BIT 4

// Reset values
`define CCR_RESET    5'h00
`define OPCODE_RESET 16'h0000

// Opcode patterns
`define DYN_TOP_ZERO   4'h0
`define DYN_INVERT     3'h5
`define DYN_CLEAR      3'h6
`define STATIC_INVERT  10'h021
`define STATIC_CLEAR   10'h022
`define EXT_TOP_ZERO   8'h00

// Destination modes and absolute sub-modes
`define MODE_DATA      3'h0
`define MODE_INDIRECT  3'h2
`define MODE_POSTINC   3'h3
`define MODE_PREDEC    3'h4
`define MODE_DISP      3'h5
`define MODE_INDEXED   3'h6
`define MODE_EXTRA     3'h7
`define ABS_SHORT      3'h0
`define ABS_LONG       3'h1
`define BYTE_STEP      32'h0000_0001

`endif

// [rtl/bit_test_pkg.sv]
package bit_test_pkg;

    // Execution sequence states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_MEM_READ,
        ST_MEM_WRITE,
        ST_FINISH
    } exec_state_t;

endpackage : bit_test_pkg

// [tb/mem_model.sv]
`timescale 1ns/100ps

// Byte-wide memory on the far side of the operand path, answering after a chosen delay
module mem_model (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic [1:0]  wait_cycles,
    output logic      [7:0]  mem_rdata,
    output logic             mem_ack,
    output logic      [31:0] last_addr,
    output int               write_count
);
    logic [7:0] mem [0:255];
    logic [1:0] wait_reg;

    // One-cycle acknowledge; read data toggles outside the ack so stale bytes never look valid
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_ack     <= 1'b0;
            wait_reg    <= 2'h0;
            mem_rdata   <= 8'h5A;
            last_addr   <= 32'h0000_0000;
            write_count <= 0;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            wait_reg  <= 2'h0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && wait_reg == wait_cycles) begin
            mem_ack <= 1'b1;
            if (mem_we) begin
                mem[mem_addr[7:0]] <= mem_wdata;
                last_addr          <= mem_addr;
                write_count        <= write_count + 1;
                mem_rdata          <= ~mem_rdata;
            end else begin
                mem_rdata <= mem[mem_addr[7:0]];
            end
        end else begin
            if (mem_req) begin
                wait_reg <= wait_reg + 2'h1;
            end
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : mem_model

// [tb/testbench.sv]
`timescale 1ns/100ps
`include "bit_test_change_clear_map.svh"

module testbench;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic        mem_ack;
    logic [1:0]  wait_cycles = 2'h0;
    logic [31:0] last_addr;
    int          write_count;
    int          mismatches = 0;
    int          num_checks = 0;

    // 100 MHz clock
    always #5 clock = ~clock;

    bit_test_change_clear dut (.clock(clock), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    mem_model mem_inst (.clock(clock), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_cycles(wait_cycles),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .last_addr(last_addr),
        .write_count(write_count));

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held until waitrequest is sampled low, then one idle cycle
    task bus_write(input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus_write

    task bus_read(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus_read

    // Opcode built from the documented bit patterns, not from the design's constants
    function logic [15:0] opc(input logic stat, input logic clr, input logic [2:0] breg,
                              input logic [2:0] mode, input logic [2:0] rg);
        if (stat)
            opc = {clr ? 10'h022 : 10'h021, mode, rg};
        else
            opc = {4'h0, breg, clr ? 3'h6 : 3'h5, mode, rg};
    endfunction : opc

    // Load operands, start, and poll until done or illegal
    task execute(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] ea,
                 output logic [31:0] st);
        bus_write(`OFS_OPCODE, {16'h0000, op});
        bus_write(`OFS_EXTENSION, {16'h0000, ext});
        bus_write(`OFS_EA_EXTENSION, ea);
        bus_write(`OFS_CONTROL, 32'h0000_0001);
        do bus_read(`OFS_STATUS, st); while (st[1] !== 1'b1 && st[2] !== 1'b1);
    endtask : execute

    task t_reset_and_unmapped;
        logic [31:0] rd;
        bus_read(`OFS_STATUS, rd);
        check("status after reset", rd, 32'h0000_0000);
        bus_read(`OFS_CCR, rd);
        check("flags after reset", rd, 32'h0000_0000);
        bus_write(8'h30, 32'hFFFF_FFFF);
        bus_read(8'h30, rd);
        check("unmapped read", rd, 32'h0000_0000);
        bus_write(`OFS_DATA_BASE, 32'h1122_3344);
        avs_byteenable <= 4'h5;
        bus_write(`OFS_DATA_BASE, 32'hAABB_CCDD);
        avs_byteenable <= 4'hF;
        bus_read(`OFS_DATA_BASE, rd);
        check("byte lanes", rd, 32'h11BB_33DD);
        $display("test reset_and_unmapped done");
    endtask : t_reset_and_unmapped

    // Both forms, both ops, bit numbers 0, 31 and one beyond 31 with upper junk
    task t_data_reg;
        logic [31:0] st, rd, val, expv;
        logic [7:0]  bn [3];
        logic        old;
        bn = '{8'h00, 8'h1F, 8'h25};
        val = 32'hA5A5_0F0F;
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 2; c++) begin
                for (int i = 0; i < 3; i++) begin
                    bus_write(`OFS_DATA_BASE + 8'h08, val);
                    bus_write(`OFS_DATA_BASE + 8'h04, {24'h000001, bn[i]});
                    bus_write(`OFS_CCR, 32'h0000_001B);
                    execute(opc(f[0], c[0], 3'h1, 3'h0, 3'h2), {8'h00, bn[i]}, 32'h0, st);
                    old = val[bn[i][4:0]];
                    expv = c ? val & ~(32'h1 << bn[i][4:0]) : val ^ (32'h1 << bn[i][4:0]);
                    bus_read(`OFS_DATA_BASE + 8'h08, rd);
                    check("data reg", rd, expv);
                    bus_read(`OFS_CCR, rd);
                    check("flags", rd, {27'h0, 2'h3, ~old, 2'h3});
                    check("status flags", {27'h0, st[8:4]}, {27'h0, 2'h3, ~old, 2'h3});
                    check("illegal bit", {31'h0, st[2]}, 32'h0);
                end
            end
        end
        $display("test data_reg done");
    endtask : t_data_reg

    // Every memory mode, alternating ops and forms, memory answering at varied speed
    task t_memory;
        logic [31:0] st, rd, ea [7], ad [7], pt [7];
        logic [2:0]  md [7], rg [7];
        logic [7:0]  bn, expb;
        int          wc;
        md = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
        rg = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h0, 3'h1};
        ea = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h14, 32'h50, 32'h70};
        ad = '{32'h20, 32'h20, 32'h1F, 32'h30, 32'h34, 32'h50, 32'h70};
        pt = '{32'h20, 32'h21, 32'h1F, 32'h20, 32'h20, 32'h20, 32'h20};
        for (int i = 0; i < 7; i++) begin
            bn = 8'h08 + i[7:0];
            wait_cycles <= i[1:0];
            mem_inst.mem[ad[i][7:0]] = 8'h96;
            wc = write_count;
            bus_write(`OFS_POINTER_BASE + 8'h0C, 32'h0000_0020);
            bus_write(`OFS_DATA_BASE + 8'h04, {24'h0, bn});
            bus_write(`OFS_CCR, 32'h0000_0000);
            execute(opc(i[1], i[0], 3'h1, md[i], rg[i]), {8'h00, bn}, ea[i], st);
            expb = i[0] ? 8'h96 & ~(8'h1 << bn[2:0]) : 8'h96 ^ (8'h1 << bn[2:0]);
            check("memory byte", {24'h0, mem_inst.mem[ad[i][7:0]]}, {24'h0, expb});
            check("write address", last_addr, ad[i]);
            check("write count", write_count, wc + 1);
            bus_read(`OFS_CCR, rd);
            check("memory flags", rd, {29'h0, !(8'h96 & (8'h1 << bn[2:0])), 2'h0});
            bus_read(`OFS_POINTER_BASE + 8'h0C, rd);
            check("pointer", rd, pt[i]);
        end
        $display("test memory done");
    endtask : t_memory

    // Rejected modes and malformed encodings leave everything untouched
    task t_illegal;
        logic [31:0] st, rd;
        logic [15:0] op [5], ext [5];
        int          wc;
        op = '{opc(1'b1, 1'b0, 3'h0, 3'h1, 3'h2), opc(1'b1, 1'b1, 3'h0, 3'h7, 3'h2),
               opc(1'b0, 1'b0, 3'h1, 3'h7, 3'h4), opc(1'b1, 1'b0, 3'h0, 3'h0, 3'h2),
               16'h01C2};
        ext = '{16'h0003, 16'h0003, 16'h0003, 16'h0103, 16'h0003};
        for (int i = 0; i < 5; i++) begin
            wc = write_count;
            bus_write(`OFS_DATA_BASE + 8'h08, 32'h0000_00FF);
            bus_write(`OFS_CCR, 32'h0000_001B);
            execute(op[i], ext[i], 32'h0000_0040, st);
            check("illegal flag", {31'h0, st[2]}, 32'h1);
            bus_read(`OFS_DATA_BASE + 8'h08, rd);
            check("reg untouched", rd, 32'h0000_00FF);
            bus_read(`OFS_CCR, rd);
            check("flags untouched", rd, 32'h0000_001B);
            check("no memory write", write_count, wc);
        end
        $display("test illegal done");
    endtask : t_illegal

    task results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_reset_and_unmapped();
        t_data_reg();
        t_memory();
        t_illegal();
        results();
    end

    // Watchdog, well beyond the fewer than a thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        results();
    end
endmodule : testbench
